/* design/ilh_pkg.sv */
`default_nettype none
package ilh_pkg;
  // Structure counts
  localparam int unsigned NUM_CH = 16;
  localparam int unsigned NUM_IS = 16;
  localparam int unsigned IDX_W  = 4;

  // Address regions: channels at 0x000 (stride 0x20), interrupt structures at 0x200 (stride 0x10)
  localparam logic [2:0] CH_REGION = 3'h0;
  localparam logic [3:0] IS_REGION = 4'h2;

  // Channel register offsets
  localparam logic [4:0] CH_LOCK_TAKE   = 5'h00;
  localparam logic [4:0] CH_SIGNAL_TRIG = 5'h04;
  localparam logic [4:0] CH_UNLOCK_TRIG = 5'h08;
  localparam logic [4:0] CH_MSG_LOW     = 5'h0C;
  localparam logic [4:0] CH_MSG_HIGH    = 5'h10;
  localparam logic [4:0] CH_LOCK_STATE  = 5'h14;

  // Interrupt structure register offsets
  localparam logic [3:0] IS_CAUSE  = 4'h0;
  localparam logic [3:0] IS_FORCE  = 4'h4;
  localparam logic [3:0] IS_ENABLE = 4'h8;
  localparam logic [3:0] IS_MASKED = 4'hC;

  // Field positions
  localparam int unsigned SIG_LSB  = 16;
  localparam int unsigned UNL_LSB  = 0;
  localparam int unsigned LOCK_BIT = 0;

  // Reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [15:0] RST_LOCK = 16'h0000;

  // Bus encodings
  localparam logic [2:0] SIZE_WORD = 3'h2;

  typedef struct packed {
    logic        ok;
    logic        write;
    logic [11:0] addr;
  } ilh_aphase_t;

  typedef enum logic [1:0] {
    BUS_IDLE      = 2'b00,
    BUS_WRITE     = 2'b01,
    BUS_READ_WAIT = 2'b10,
    BUS_READ_DONE = 2'b11
  } ilh_bus_state_t;
endpackage : ilh_pkg
`default_nettype wire

/* design/ilh_lock_event_hub.sv */
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// RQ1 - Each channel has a lock taken via lock_take; lock state register readable.
// RQ2 - Signal trigger write raises signal event in each structure whose bit is one.
// RQ3 - Unlock trigger frees lock and raises unlock events, only while lock held.
// RQ4 - One unlock write both frees the lock and raises the events.
// RQ5 - Signal and unlock trigger registers always read as zero.
// RQ6 - Each channel holds two 32-bit message words, 64 bits together.
// RQ7 - Cause bits 31:16 set by signal, 15:0 by unlock; write one clears.
// RQ8 - Force register write of one sets cause bit; zero leaves it alone.
// RQ9 - Enable register has one bit per cause bit, both halves.
// RQ10 - Masked view reads as cause AND enable.
// RQ11 - Trigger bit n targets structure n; cause bits identify source channel.
// RQ12 - Signal cause bits 31 down to 16 map to channels 15 down to 0.
// RQ13 - Any channel triggers any structure; one write may trigger several.
// RQ14 - Structures raise interrupt requests for signal and unlock events.
// RQ15 - Software reads back after writes that must take effect first.
// RQ16 - Polled sync: producer writes agreed value to low word, consumer polls.
// RQ17 - Lock_take read grants lock only if free and reports the outcome.
// RQ18 - Each structure drives its interrupt while any masked bit is one.
module ilh_lock_event_hub (
  input  wire logic                        hclk,
  input  wire logic                        hresetn,
  input  wire logic                        ce,
  input  wire logic                        hsel,
  input  wire logic [31:0]                 haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [31:0]                 hwdata,
  input  wire logic                        hready,
  output logic                             hreadyout,
  output logic                             hresp,
  output logic [31:0]                      hrdata,
  output logic [ilh_pkg::NUM_IS-1:0]       irq_vec,
  output logic                             irq_any
);

  ilh_pkg::ilh_aphase_t    ap_reg;
  ilh_pkg::ilh_aphase_t    ap_next;
  ilh_pkg::ilh_bus_state_t bus_reg;
  ilh_pkg::ilh_bus_state_t bus_next;
  logic [31:0]             hrdata_reg;
  logic [31:0]             hrdata_next;
  logic [31:0]             rd_val;

  wire  [ilh_pkg::NUM_CH-1:0] lock_all;
  wire  [31:0]                msg_lo_all [ilh_pkg::NUM_CH];
  wire  [31:0]                msg_hi_all [ilh_pkg::NUM_CH];
  wire  [31:0]                cause_all  [ilh_pkg::NUM_IS];
  wire  [31:0]                enable_all [ilh_pkg::NUM_IS];

  // Data-phase decode
  logic                       is_ch;
  logic                       is_is;
  logic [ilh_pkg::IDX_W-1:0]  ch_idx;
  logic [ilh_pkg::IDX_W-1:0]  is_idx;
  logic [4:0]                 ch_off;
  logic [3:0]                 is_off;
  logic [15:0]                ch_onehot;
  logic                       wr_go;
  logic                       rd_go;
  logic                       take_go;
  logic                       wr_sig;
  logic                       wr_unl_any;
  logic                       wr_unl;
  logic                       wr_lo;
  logic                       wr_hi;
  logic                       wr_cause;
  logic                       wr_force;
  logic                       wr_enable;

  assign is_ch     = ap_reg.ok && (ap_reg.addr[11:9] == ilh_pkg::CH_REGION);
  assign is_is     = ap_reg.ok && (ap_reg.addr[11:8] == ilh_pkg::IS_REGION);
  assign ch_idx    = ap_reg.addr[8:5];
  assign ch_off    = ap_reg.addr[4:0];
  assign is_idx    = ap_reg.addr[7:4];
  assign is_off    = ap_reg.addr[3:0];
  assign ch_onehot = 16'h0001 << ch_idx;

  assign wr_go      = ce && (bus_reg == ilh_pkg::BUS_WRITE);
  assign rd_go      = ce && (bus_reg == ilh_pkg::BUS_READ_WAIT);
  // RQ17 atomic take
  assign take_go    = rd_go && is_ch && (ch_off == ilh_pkg::CH_LOCK_TAKE);
  assign wr_sig     = wr_go && is_ch && (ch_off == ilh_pkg::CH_SIGNAL_TRIG);
  assign wr_unl_any = wr_go && is_ch && (ch_off == ilh_pkg::CH_UNLOCK_TRIG);
  // RQ3 held lock only
  assign wr_unl     = wr_unl_any && lock_all[ch_idx];
  assign wr_lo      = wr_go && is_ch && (ch_off == ilh_pkg::CH_MSG_LOW);
  assign wr_hi      = wr_go && is_ch && (ch_off == ilh_pkg::CH_MSG_HIGH);
  assign wr_cause   = wr_go && is_is && (is_off == ilh_pkg::IS_CAUSE);
  assign wr_force   = wr_go && is_is && (is_off == ilh_pkg::IS_FORCE);
  assign wr_enable  = wr_go && is_is && (is_off == ilh_pkg::IS_ENABLE);

  // Bus slave: writes zero wait, reads one wait state so data comes from a flop
  always_comb begin
    bus_next = bus_reg;
    ap_next  = ap_reg;
    if (hready) begin
      if (hsel && htrans[1]) begin
        ap_next.ok    = (hsize == ilh_pkg::SIZE_WORD) && (haddr[31:12] == 20'h0_0000);
        ap_next.write = hwrite;
        ap_next.addr  = haddr[11:0];
        bus_next      = hwrite ? ilh_pkg::BUS_WRITE : ilh_pkg::BUS_READ_WAIT;
      end else begin
        bus_next = ilh_pkg::BUS_IDLE;
      end
    end else if (bus_reg == ilh_pkg::BUS_READ_WAIT) begin
      bus_next = ilh_pkg::BUS_READ_DONE;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_reg <= ilh_pkg::BUS_IDLE;
      ap_reg  <= '0;
    end else if (ce) begin
      bus_reg <= bus_next;
      ap_reg  <= ap_next;
    end
  end

  assign hreadyout = (bus_reg != ilh_pkg::BUS_READ_WAIT);
  assign hresp     = 1'b0;

  // Read mux; unmapped addresses read zero
  always_comb begin
    rd_val = ilh_pkg::RST_WORD;
    if (is_ch) begin
      case (ch_off)
        // RQ17 grant report
        ilh_pkg::CH_LOCK_TAKE:   rd_val[ilh_pkg::LOCK_BIT] = !lock_all[ch_idx];
        // RQ1 lock state view
        ilh_pkg::CH_LOCK_STATE:  rd_val[ilh_pkg::LOCK_BIT] = lock_all[ch_idx];
        // RQ6 message words
        ilh_pkg::CH_MSG_LOW:     rd_val = msg_lo_all[ch_idx];
        ilh_pkg::CH_MSG_HIGH:    rd_val = msg_hi_all[ch_idx];
        // RQ5 triggers read zero
        ilh_pkg::CH_SIGNAL_TRIG: rd_val = ilh_pkg::RST_WORD;
        ilh_pkg::CH_UNLOCK_TRIG: rd_val = ilh_pkg::RST_WORD;
        default:                 rd_val = ilh_pkg::RST_WORD;
      endcase
    end else if (is_is) begin
      case (is_off)
        ilh_pkg::IS_CAUSE:  rd_val = cause_all[is_idx];
        ilh_pkg::IS_FORCE:  rd_val = cause_all[is_idx];
        ilh_pkg::IS_ENABLE: rd_val = enable_all[is_idx];
        // RQ10 masked view
        ilh_pkg::IS_MASKED: rd_val = cause_all[is_idx] & enable_all[is_idx];
        default:            rd_val = ilh_pkg::RST_WORD;
      endcase
    end
  end

  always_comb begin
    hrdata_next = hrdata_reg;
    if (rd_go) begin
      hrdata_next = rd_val;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= ilh_pkg::RST_WORD;
    end else if (ce) begin
      hrdata_reg <= hrdata_next;
    end
  end

  assign hrdata = hrdata_reg;

  // Channel structures
  for (genvar c = 0; c < ilh_pkg::NUM_CH; c++) begin : g_ch
    localparam logic [ilh_pkg::IDX_W-1:0] CH_ID = ilh_pkg::IDX_W'(c);
    logic        lock_reg;
    logic        lock_next;
    logic [31:0] lo_reg;
    logic [31:0] lo_next;
    logic [31:0] hi_reg;
    logic [31:0] hi_next;

    always_comb begin
      lock_next = lock_reg;
      lo_next   = lo_reg;
      hi_next   = hi_reg;
      // RQ1 take sets lock
      if (take_go && (ch_idx == CH_ID)) begin
        lock_next = 1'b1;
      end
      // RQ4 unlock frees lock
      if (wr_unl && (ch_idx == CH_ID)) begin
        lock_next = 1'b0;
      end
      // RQ6 message storage
      if (wr_lo && (ch_idx == CH_ID)) begin
        lo_next = hwdata;
      end
      if (wr_hi && (ch_idx == CH_ID)) begin
        hi_next = hwdata;
      end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        lock_reg <= ilh_pkg::RST_LOCK[c];
        lo_reg   <= ilh_pkg::RST_WORD;
        hi_reg   <= ilh_pkg::RST_WORD;
      end else if (ce) begin
        lock_reg <= lock_next;
        lo_reg   <= lo_next;
        hi_reg   <= hi_next;
      end
    end

    assign lock_all[c]   = lock_reg;
    assign msg_lo_all[c] = lo_reg;
    assign msg_hi_all[c] = hi_reg;
  end

  // Interrupt structures
  for (genvar i = 0; i < ilh_pkg::NUM_IS; i++) begin : g_is
    localparam logic [ilh_pkg::IDX_W-1:0] IS_ID = ilh_pkg::IDX_W'(i);
    logic [31:0] cause_reg;
    logic [31:0] cause_next;
    logic [31:0] enable_reg;
    logic [31:0] enable_next;
    logic [31:0] ev_set;
    logic [31:0] sw_clr;
    logic [31:0] sw_set;

    always_comb begin
      ev_set = ilh_pkg::RST_WORD;
      // RQ11 bit i targets structure i
      // RQ12 signal half maps channel
      // RQ2 signal event
      if (wr_sig && hwdata[i]) begin
        ev_set[ilh_pkg::SIG_LSB +: 16] = ch_onehot;
      end
      // RQ3 unlock event
      if (wr_unl && hwdata[i]) begin
        ev_set[ilh_pkg::UNL_LSB +: 16] = ch_onehot;
      end
      sw_clr      = (wr_cause && (is_idx == IS_ID)) ? hwdata : ilh_pkg::RST_WORD;
      sw_set      = (wr_force && (is_idx == IS_ID)) ? hwdata : ilh_pkg::RST_WORD;
      // RQ7 w1c, set wins
      // RQ8 force sets
      cause_next  = (cause_reg & ~sw_clr) | ev_set | sw_set;
      // RQ9 enable per bit
      enable_next = (wr_enable && (is_idx == IS_ID)) ? hwdata : enable_reg;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        cause_reg  <= ilh_pkg::RST_WORD;
        enable_reg <= ilh_pkg::RST_WORD;
      end else if (ce) begin
        cause_reg  <= cause_next;
        enable_reg <= enable_next;
      end
    end

    assign cause_all[i]  = cause_reg;
    assign enable_all[i] = enable_reg;
    // RQ18 level interrupt
    // RQ14 event interrupts
    assign irq_vec[i]    = |(cause_reg & enable_reg);
  end

  // RQ13 fan-out summary
  assign irq_any = |irq_vec;

  // Checks
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_rd_addr;
    ce && hsel && htrans[1] && hready && !hwrite;
  endsequence

  sequence s_rd_stall;
    !hreadyout && (bus_reg == ilh_pkg::BUS_READ_WAIT);
  endsequence

  a_read_stall_once: assert property (s_rd_addr |=> s_rd_stall ##1 (hreadyout || !ce)) // RQ5
    else $error("read did not stall for exactly one cycle");

  a_take_grant_free: assert property (take_go && !lock_all[ch_idx] // RQ17
      |=> lock_all[$past(ch_idx)] && (hrdata[0] == 1'b1))
    else $error("free lock not granted on take");

  a_take_busy_deny: assert property (take_go && lock_all[ch_idx] // RQ1
      |=> lock_all[$past(ch_idx)] && (hrdata == 32'h0000_0000))
    else $error("held lock reported as granted");

  a_unlock_frees_lock: assert property (wr_unl |=> !lock_all[$past(ch_idx)]) // RQ4
    else $error("unlock write did not free lock");

  a_unlock_idle_none: assert property (wr_unl_any && !lock_all[ch_idx] // RQ3
      |=> $stable(lock_all) && (cause_all[0][15:0] == $past(cause_all[0][15:0])))
    else $error("unlock of free lock had an effect");

  a_unlock_event_sets: assert property (wr_unl && hwdata[0] // RQ3
      |=> cause_all[0][$past(ch_idx)])
    else $error("unlock event missing in structure 0");

  a_signal_event_sets: assert property (wr_sig && hwdata[0] // RQ12
      |=> cause_all[0][5'(ilh_pkg::SIG_LSB) + 5'($past(ch_idx))])
    else $error("signal event missing in structure 0");

  a_trig_read_zero: assert property (rd_go && is_ch // RQ5
      && ((ch_off == ilh_pkg::CH_SIGNAL_TRIG) || (ch_off == ilh_pkg::CH_UNLOCK_TRIG))
      |=> hrdata == 32'h0000_0000)
    else $error("trigger register read nonzero");

  a_cause_w1c_clear: assert property (wr_cause // RQ7
      |=> (cause_all[$past(is_idx)] & $past(hwdata)) == 32'h0000_0000)
    else $error("write one did not clear cause");

  a_force_sets_bits: assert property (wr_force // RQ8
      |=> (cause_all[$past(is_idx)] & $past(hwdata)) == $past(hwdata))
    else $error("force write did not set cause");

  a_masked_view_read: assert property (rd_go && is_is && (is_off == ilh_pkg::IS_MASKED) // RQ10
      |=> hrdata == $past(cause_all[is_idx] & enable_all[is_idx]))
    else $error("masked view read wrong");

  a_irq_raise_force: assert property (wr_force // RQ18
      && ((hwdata & enable_all[is_idx]) != 32'h0000_0000) |=> irq_vec[$past(is_idx)] && irq_any)
    else $error("interrupt not raised after enabled force");

  a_msg_low_store: assert property (wr_lo |=> msg_lo_all[$past(ch_idx)] == $past(hwdata)) // RQ6
    else $error("low message word not stored");

  sequence s_sig_both_ends;
    wr_sig && hwdata[0] && hwdata[15];
  endsequence

  sequence s_state_read;
    rd_go && is_ch && (ch_off == ilh_pkg::CH_LOCK_STATE);
  endsequence

  a_signal_fanout_both: assert property (s_sig_both_ends // RQ13
      |=> cause_all[0][5'(ilh_pkg::SIG_LSB) + 5'($past(ch_idx))]
          && cause_all[15][5'(ilh_pkg::SIG_LSB) + 5'($past(ch_idx))])
    else $error("signal event not delivered to every target");

  a_untargeted_stable: assert property (wr_sig && !hwdata[7] // RQ11
      |=> $stable(cause_all[7]))
    else $error("signal event reached an untargeted structure");

  a_unlock_skip_stable: assert property (wr_unl && !hwdata[1] // RQ3
      |=> $stable(cause_all[1]))
    else $error("unlock event reached an unselected structure");

  a_msg_high_store: assert property (wr_hi |=> msg_hi_all[$past(ch_idx)] == $past(hwdata)) // RQ6
    else $error("high message word not stored");

  a_enable_write: assert property (wr_enable // RQ9
      |=> enable_all[$past(is_idx)] == $past(hwdata))
    else $error("enable register write not stored");

  a_state_read_view: assert property (s_state_read // RQ1
      |=> hrdata == {31'h0000_0000, $past(lock_all[ch_idx])})
    else $error("lock state read wrong");

  a_w1c_keeps_others: assert property (wr_cause // RQ7
      |=> (cause_all[$past(is_idx)] & ~$past(hwdata))
          == ($past(cause_all[is_idx]) & ~$past(hwdata)))
    else $error("write one to clear disturbed other cause bits");

  a_read_data_holds: assert property (!rd_go |=> $stable(hrdata)) // RQ17
    else $error("read data changed outside a read");

endmodule : ilh_lock_event_hub
`default_nettype wire

/* dv/ilh_cpu_model.sv */
`timescale 1ns/1ns
`default_nettype none
module ilh_cpu_model (
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  initial begin
    hsel = 1'b1;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = ilh_pkg::SIZE_WORD;
    hwdata = 32'h0000_0000;
  end

  // Entered just after a rising edge; stale write data is inverted during the address phase
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= w;
    hsize  <= ilh_pkg::SIZE_WORD;
    hwdata <= ~hwdata;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask : xfer

  task automatic wr_rb(input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    logic [31:0] u;
    xfer(1'b1, a, d, u);
    xfer(1'b0, a, 32'h0000_0000, q);
  endtask : wr_rb

  // poll the low word for an agreed value
  task automatic poll(input logic [31:0] a, input logic [31:0] v, output bit hit);
    logic [31:0] q;
    hit = 1'b0;
    for (int k = 0; k < 8 && !hit; k++) begin
      xfer(1'b0, a, 32'h0000_0000, q);
      hit = (q === v);
    end
  endtask : poll
endmodule : ilh_cpu_model
`default_nettype wire

/* dv/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  localparam logic [31:0] ZW = 32'h0000_0000;
  logic        hclk;
  logic        hresetn;
  logic        ce;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hready;
  logic        hresp;
  logic [31:0] hrdata;
  logic [15:0] irq_vec;
  logic        irq_any;
  int          error_cnt = 0;
  int          cmp_count = 0;

  ilh_cpu_model mst_u (.hclk(hclk), .hready(hready), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  ilh_lock_event_hub dut_u (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
    .irq_vec(irq_vec), .irq_any(irq_any));

  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  function automatic logic [31:0] ch(int c, logic [4:0] o);
    return 32'(c * 32) + {27'h000_0000, o};
  endfunction : ch
  function automatic logic [31:0] is(int i, logic [3:0] o);
    return 32'h0000_0200 + 32'(i * 16) + {28'h000_0000, o};
  endfunction : is

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] u;
    mst_u.xfer(1'b1, a, d, u);
  endtask : wr
  task automatic rd(input logic [31:0] a, output logic [31:0] q);
    mst_u.xfer(1'b0, a, ZW, q);
  endtask : rd

  task automatic t_irq;
    logic [31:0] q;
    rd(is(2, ilh_pkg::IS_ENABLE), q);
    chk(q, ZW, "enable reset");
    mst_u.wr_rb(is(2, ilh_pkg::IS_ENABLE), 32'h0004_0000, q);
    chk(q, 32'h0004_0000, "enable rw");
    wr(is(2, ilh_pkg::IS_FORCE), 32'h0004_0001);
    @(posedge hclk);
    chk({16'h0000, irq_vec}, 32'h0000_0004, "irq vector");
    chk({31'h0000_0000, irq_any}, 32'h0000_0001, "irq any");
    wr(is(2, ilh_pkg::IS_FORCE), ZW);
    rd(is(2, ilh_pkg::IS_CAUSE), q);
    chk(q, 32'h0004_0001, "force sets");
    rd(is(2, ilh_pkg::IS_MASKED), q);
    chk(q, 32'h0004_0000, "masked view");
    wr(is(2, ilh_pkg::IS_CAUSE), 32'h0004_0000);
    @(posedge hclk);
    chk({16'h0000, irq_vec}, ZW, "irq cleared");
    mst_u.wr_rb(is(2, ilh_pkg::IS_CAUSE), 32'hFFFF_FFFF, q);
    chk(q, ZW, "w1c clear");
  endtask : t_irq

  task automatic t_lock;
    logic [31:0] q;
    rd(ch(5, ilh_pkg::CH_LOCK_STATE), q);
    chk(q, ZW, "lock free");
    rd(ch(5, ilh_pkg::CH_LOCK_TAKE), q);
    chk(q, 32'h0000_0001, "granted");
    rd(ch(5, ilh_pkg::CH_LOCK_TAKE), q);
    chk(q, ZW, "refused");
    rd(ch(5, ilh_pkg::CH_LOCK_STATE), q);
    chk(q, 32'h0000_0001, "lock held");
    wr(ch(5, ilh_pkg::CH_UNLOCK_TRIG), 32'h0000_0009);
    rd(ch(5, ilh_pkg::CH_LOCK_STATE), q);
    chk(q, ZW, "unlocked");
    rd(is(3, ilh_pkg::IS_CAUSE), q);
    chk(q, 32'h0000_0020, "unlock event");
    wr(ch(5, ilh_pkg::CH_UNLOCK_TRIG), 32'h0000_0003);
    rd(is(1, ilh_pkg::IS_CAUSE), q);
    chk(q, ZW, "no event when free");
    rd(ch(5, ilh_pkg::CH_UNLOCK_TRIG), q);
    chk(q, ZW, "unlock reads 0");
    wr(is(0, ilh_pkg::IS_CAUSE), 32'hFFFF_FFFF);
    wr(is(3, ilh_pkg::IS_CAUSE), 32'hFFFF_FFFF);
  endtask : t_lock

  task automatic t_signal;
    logic [31:0] q;
    wr(ch(15, ilh_pkg::CH_SIGNAL_TRIG), 32'h0000_8001);
    wr(ch(0, ilh_pkg::CH_SIGNAL_TRIG), 32'h0000_0001);
    rd(is(0, ilh_pkg::IS_CAUSE), q);
    chk(q, 32'h8001_0000, "two sources");
    rd(is(15, ilh_pkg::IS_CAUSE), q);
    chk(q, 32'h8000_0000, "multi target");
    rd(is(7, ilh_pkg::IS_CAUSE), q);
    chk(q, ZW, "untargeted");
    rd(ch(15, ilh_pkg::CH_SIGNAL_TRIG), q);
    chk(q, ZW, "signal reads 0");
    mst_u.wr_rb(is(0, ilh_pkg::IS_CAUSE), 32'h8000_0000, q);
    chk(q, 32'h0001_0000, "partial clear");
    wr(is(0, ilh_pkg::IS_CAUSE), 32'hFFFF_FFFF);
    wr(is(15, ilh_pkg::IS_CAUSE), 32'hFFFF_FFFF);
  endtask : t_signal

  task automatic t_msg;
    logic [31:0] q;
    bit          hit;
    wr(ch(9, ilh_pkg::CH_MSG_LOW), 32'hA5C3_0F01);
    wr(ch(9, ilh_pkg::CH_MSG_HIGH), 32'h5A3C_F0FE);
    mst_u.poll(ch(9, ilh_pkg::CH_MSG_LOW), 32'hA5C3_0F01, hit);
    chk({31'h0000_0000, hit}, 32'h0000_0001, "low word");
    wr(32'h0000_1000 + ch(9, ilh_pkg::CH_MSG_HIGH), 32'h1111_1111);
    rd(ch(9, ilh_pkg::CH_MSG_HIGH), q);
    chk(q, 32'h5A3C_F0FE, "high word");
    rd(32'h0000_1000, q);
    chk(q, ZW, "unmapped read");
    chk({31'h0000_0000, hresp}, ZW, "okay response");
  endtask : t_msg

  task automatic print_verdict;
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict

  initial begin
    #200_000;
    error_cnt++;
    $display("unexpected at %0t: watchdog expired", $time);
    print_verdict();
  end

  initial begin
    hresetn = 1'b0;
    ce = 1'b1;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_irq();
    t_lock();
    t_signal();
    t_msg();
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
